// File: rtl/cpm_pkg.sv
// package: constants for the cpu programmers model register file
package cpm_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 5;
    localparam int SP_LOW_W = 6;

    // memory map (byte addresses)
    localparam logic [12:0] RAM_LO = 13'h0080;
    localparam logic [12:0] RAM_HI = 13'h01ff;
    localparam logic [12:0] EPROM_LO = 13'h0b00;
    localparam logic [12:0] EPROM_HI = 13'h1eff;
    localparam logic [12:0] OPTION_ADDR = 13'h1f00;
    localparam logic [12:0] BOOT_LO = 13'h1f01;
    localparam logic [12:0] BOOT_HI = 13'h1fef;
    localparam logic [12:0] VEC_LO = 13'h1ff0;
    localparam logic [12:0] VEC_DED_LO = 13'h1ff2;
    localparam logic [12:0] VEC_HI = 13'h1fff;
    localparam logic [12:0] RESET_VEC = 13'h1ffe;

    // stack address formation
    localparam logic [6:0] SP_HIGH_BITS = 7'h03;
    localparam logic [12:0] SP_RESET = 13'h00ff;
    localparam logic [5:0] SP_LOW_RESET = 6'h3f;

    // flag bit positions
    localparam int FLG_H = 4;
    localparam int FLG_I = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;
    localparam logic [4:0] FLAG_RESET = 5'h08;

    // push counts
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] IRQ_BYTES = 3'h5;

    // register port offsets
    localparam logic [3:0] OFS_ACC = 4'h0;
    localparam logic [3:0] OFS_IDX = 4'h1;
    localparam logic [3:0] OFS_FLAGS = 4'h2;
    localparam logic [3:0] OFS_SP = 4'h3;
    localparam logic [3:0] OFS_PC_LO = 4'h4;
    localparam logic [3:0] OFS_PC_HI = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;
    localparam logic [3:0] OFS_SPADDR_LO = 4'h7;

    // region codes
    typedef enum logic [2:0] {
        CPM_REG_NONE, CPM_REG_RAM, CPM_REG_EPROM, CPM_REG_OPTION,
        CPM_REG_BOOT, CPM_REG_VEC
    } cpm_region_t;

    // sequencer ops
    typedef enum logic [3:0] {
        CPM_OP_NONE, CPM_OP_RSP, CPM_OP_ALU, CPM_OP_CARRY, CPM_OP_CALL,
        CPM_OP_RTS, CPM_OP_INT, CPM_OP_RTI, CPM_OP_CLI, CPM_OP_SEI,
        CPM_OP_JUMP, CPM_OP_INC_PC
    } cpm_op_t;

endpackage

// File: rtl/cpm_core.sv
// module: programmer-visible registers, stack engine and address decode
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// RL1: eprom 0b00-1eff, user vectors 1ff0-1fff
// RL2: boot rom 1f01-1fef, option byte 1f00
// RL3: 1ff2-1fff dedicated to reset/interrupt vectors
// RL4: ram 0080-01ff, 384 bytes
// RL5: push pointer 00ff on reset, stack home
// RL6: post-decrement push, pre-increment pull
// RL7: stack address upper bits forced 0000011
// RL8: six-bit pointer wraps silently modulo 64
// RL9: call pushes two, interrupt pushes five
// RL10: pc low first, reverse on pull
// RL11: work reg holds alu operands/results
// RL12: offset reg forms indexed addresses
// RL13: five flags h i n z c
// RL14: half carry from bit 3 add
// RL15: masked interrupts stay latched until unmasked
// RL16: negative flag follows result msb
// RL17: zero flag set on zero result
// RL18: carry flag from alu, shift, bit test
// RL19: fetch pointer 13 bits, next byte address
// RL20: all addresses truncated to 8 kbyte
module cpm_core (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // sequencer side
    input wire cpm_pkg::cpm_op_t op_i,
    input wire logic [7:0] alu_result_i,
    input wire logic alu_half_i,
    input wire logic alu_carry_i,
    input wire logic alu_is_add_i,
    input wire logic alu_to_index_i,
    input wire logic [12:0] jump_addr_i,
    input wire logic [12:0] mem_addr_i,
    // interrupt requests from peripherals (other domain)
    input wire logic ext_irq_i,
    input wire logic timer_irq_i,
    // memory side
    output logic [12:0] stack_addr_o,
    output logic [7:0] stack_wdata_o,
    output logic stack_we_o,
    output logic stack_re_o,
    output logic [2:0] region_o,
    output logic int_pending_o
);
    import cpm_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [4:0] flags_q;
    logic [5:0] sp_q;
    logic [12:0] pc_q;
    logic [2:0] push_left_q;
    logic push_is_int_q;
    logic [2:0] pull_left_q;
    logic pull_is_int_q;
    logic [4:0] push_flags_q;
    logic [1:0] ext_sync_q;
    logic [1:0] tmr_sync_q;
    logic ext_prev_q;
    logic tmr_prev_q;
    logic ext_latch_q;
    logic tmr_latch_q;
    logic [2:0] region_q;

    // ------------------------------------------------------------
    // stack address and data
    // ------------------------------------------------------------
    logic [5:0] sp_pull;
    logic [7:0] push_byte;
    logic busy;
    assign sp_pull = sp_q + 6'h01; // RL6 RL8
    assign busy = (push_left_q != 3'h0) || (pull_left_q != 3'h0);

    // byte order: pcl, pch, x, a, flags; pull reverses it
    always_comb begin
        push_byte = 8'h00;
        if (push_is_int_q) begin
            case (push_left_q)
                3'h5: push_byte = pc_q[7:0]; // RL10
                3'h4: push_byte = {3'h0, pc_q[12:8]};
                3'h3: push_byte = idx_q;
                3'h2: push_byte = acc_q;
                3'h1: push_byte = {3'h7, push_flags_q}; // RL10
                default: push_byte = 8'h00;
            endcase
        end else begin
            if (push_left_q == CALL_BYTES) begin
                push_byte = pc_q[7:0]; // RL10
            end else begin
                push_byte = {3'h0, pc_q[12:8]};
            end
        end
    end

    // stack bus outputs registered
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stack_addr_o <= SP_RESET;
            stack_wdata_o <= 8'h00;
            stack_we_o <= 1'b0;
            stack_re_o <= 1'b0;
        end else if (push_left_q != 3'h0) begin
            stack_addr_o <= {SP_HIGH_BITS, sp_q}; // RL7
            stack_wdata_o <= push_byte;
            stack_we_o <= 1'b1;
            stack_re_o <= 1'b0;
        end else if (pull_left_q != 3'h0) begin
            stack_addr_o <= {SP_HIGH_BITS, sp_pull}; // RL7 RL6
            stack_wdata_o <= 8'h00;
            stack_we_o <= 1'b0;
            stack_re_o <= 1'b1;
        end else begin
            stack_addr_o <= {SP_HIGH_BITS, sp_q};
            stack_we_o <= 1'b0;
            stack_re_o <= 1'b0;
        end
    end

    // push and pull sequencing
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            push_left_q <= 3'h0;
            push_is_int_q <= 1'b0;
            push_flags_q <= FLAG_RESET;
            pull_left_q <= 3'h0;
            pull_is_int_q <= 1'b0;
        end else if (!busy && op_i == CPM_OP_CALL) begin
            push_left_q <= CALL_BYTES; // RL9
            push_is_int_q <= 1'b0;
        end else if (!busy && op_i == CPM_OP_INT) begin
            push_left_q <= IRQ_BYTES; // RL9
            push_is_int_q <= 1'b1;
            // flags as they stood before entry sets the mask
            push_flags_q <= flags_q; // RL10
        end else if (!busy && op_i == CPM_OP_RTS) begin
            pull_left_q <= CALL_BYTES;
            pull_is_int_q <= 1'b0;
        end else if (!busy && op_i == CPM_OP_RTI) begin
            pull_left_q <= IRQ_BYTES;
            pull_is_int_q <= 1'b1;
        end else begin
            if (push_left_q != 3'h0) begin
                push_left_q <= push_left_q - 3'h1;
            end
            if (pull_left_q != 3'h0) begin
                pull_left_q <= pull_left_q - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // push pointer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sp_q <= SP_LOW_RESET; // RL5
        end else if (!busy && op_i == CPM_OP_RSP) begin
            sp_q <= SP_LOW_RESET; // RL5
        end else if (push_left_q != 3'h0) begin
            sp_q <= sp_q - 6'h01; // RL6 RL8
        end else if (pull_left_q != 3'h0) begin
            sp_q <= sp_pull; // RL6
        end else if (reg_wr_i && reg_addr_i == OFS_SP) begin
            sp_q <= reg_wdata_i[5:0];
        end
    end

    // ------------------------------------------------------------
    // fetch pointer, loaded by jump, increment or register port writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pc_q <= RESET_VEC;
        end else if (!busy && op_i == CPM_OP_JUMP) begin
            pc_q <= jump_addr_i; // RL19 RL20
        end else if (!busy && op_i == CPM_OP_INC_PC) begin
            pc_q <= pc_q + 13'h0001; // RL19 RL20
        end else if (reg_wr_i && reg_addr_i == OFS_PC_LO) begin
            pc_q[7:0] <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == OFS_PC_HI) begin
            pc_q[12:8] <= reg_wdata_i[4:0]; // RL20
        end
    end

    // ------------------------------------------------------------
    // work and offset registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_q <= 8'h00;
            idx_q <= 8'h00;
        end else if (op_i == CPM_OP_ALU && !busy) begin
            if (alu_to_index_i) begin
                idx_q <= alu_result_i; // RL12
            end else begin
                acc_q <= alu_result_i; // RL11
            end
        end else if (reg_wr_i && reg_addr_i == OFS_ACC) begin
            acc_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == OFS_IDX) begin
            idx_q <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flags_q <= FLAG_RESET;
        end else if (!busy && op_i == CPM_OP_INT) begin
            flags_q[FLG_I] <= 1'b1;
        end else if (!busy && op_i == CPM_OP_SEI) begin
            flags_q[FLG_I] <= 1'b1;
        end else if (!busy && op_i == CPM_OP_CLI) begin
            flags_q[FLG_I] <= 1'b0;
        end else if (!busy && op_i == CPM_OP_ALU) begin
            if (alu_is_add_i) begin
                flags_q[FLG_H] <= alu_half_i; // RL14
            end
            flags_q[FLG_N] <= alu_result_i[7]; // RL16
            flags_q[FLG_Z] <= (alu_result_i == 8'h00); // RL17
            flags_q[FLG_C] <= alu_carry_i; // RL18
        end else if (!busy && op_i == CPM_OP_CARRY) begin
            flags_q[FLG_C] <= alu_carry_i; // RL18
        end else if (reg_wr_i && reg_addr_i == OFS_FLAGS) begin
            flags_q <= reg_wdata_i[4:0]; // RL13
        end
    end

    // ------------------------------------------------------------
    // interrupt request latches
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_sync_q <= 2'b00;
            tmr_sync_q <= 2'b00;
            ext_prev_q <= 1'b0;
            tmr_prev_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_irq_i};
            tmr_sync_q <= {tmr_sync_q[0], timer_irq_i};
            ext_prev_q <= ext_sync_q[1];
            tmr_prev_q <= tmr_sync_q[1];
        end
    end

    // a new edge wins over the clear taken at interrupt entry
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_latch_q <= 1'b0;
            tmr_latch_q <= 1'b0;
        end else begin
            if (ext_sync_q[1] && !ext_prev_q) begin
                ext_latch_q <= 1'b1; // RL15
            end else if (!busy && op_i == CPM_OP_INT && ext_latch_q) begin
                ext_latch_q <= 1'b0;
            end
            if (tmr_sync_q[1] && !tmr_prev_q) begin
                tmr_latch_q <= 1'b1; // RL15
            end else if (!busy && op_i == CPM_OP_INT && !ext_latch_q) begin
                tmr_latch_q <= 1'b0;
            end
        end
    end

    // pending only while mask flag is clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            int_pending_o <= 1'b0;
        end else begin
            int_pending_o <= (ext_latch_q | tmr_latch_q) & ~flags_q[FLG_I]; // RL15
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            region_q <= CPM_REG_NONE;
        end else if (mem_addr_i >= RAM_LO && mem_addr_i <= RAM_HI) begin
            region_q <= CPM_REG_RAM; // RL4
        end else if (mem_addr_i >= EPROM_LO && mem_addr_i <= EPROM_HI) begin
            region_q <= CPM_REG_EPROM; // RL1
        end else if (mem_addr_i == OPTION_ADDR) begin
            region_q <= CPM_REG_OPTION; // RL2
        end else if (mem_addr_i >= BOOT_LO && mem_addr_i <= BOOT_HI) begin
            region_q <= CPM_REG_BOOT; // RL2
        end else if (mem_addr_i >= VEC_LO) begin
            region_q <= CPM_REG_VEC; // RL1 RL3
        end else begin
            region_q <= CPM_REG_NONE;
        end
    end
    assign region_o = region_q;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == OFS_ACC) begin
                reg_rdata_o <= acc_q;
            end else if (reg_addr_i == OFS_IDX) begin
                reg_rdata_o <= idx_q;
            end else if (reg_addr_i == OFS_FLAGS) begin
                reg_rdata_o <= {3'h0, flags_q};
            end else if (reg_addr_i == OFS_SP) begin
                reg_rdata_o <= {2'h0, sp_q};
            end else if (reg_addr_i == OFS_PC_LO) begin
                reg_rdata_o <= pc_q[7:0];
            end else if (reg_addr_i == OFS_PC_HI) begin
                reg_rdata_o <= {3'h0, pc_q[12:8]};
            end else if (reg_addr_i == OFS_STATUS) begin
                reg_rdata_o <= {5'h00, busy, ext_latch_q, tmr_latch_q};
            end else if (reg_addr_i == OFS_SPADDR_LO) begin
                reg_rdata_o <= {SP_HIGH_BITS[1:0], sp_q}; // RL7
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule // cpm_core

// File: tb/cpm_core_assertions.sv
// checker: stack engine and address decode relations
`timescale 1ns/100ps
module cpm_core_assertions (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // watched ports
    input wire cpm_pkg::cpm_op_t op_i,
    input wire logic [12:0] mem_addr_i,
    input wire logic [12:0] stack_addr_o,
    input wire logic stack_we_o,
    input wire logic stack_re_o,
    input wire logic [2:0] region_o
);
    import cpm_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_stack_page: assert property (
        stack_addr_o[12:6] == 7'h03) else $error("stack page left");
    a_call_two: assert property (
        $rose(stack_we_o) && $past(op_i, 2) == CPM_OP_CALL
        |-> stack_we_o ##1 stack_we_o ##1 !stack_we_o)
        else $error("call push count wrong");
    a_int_five: assert property (
        $rose(stack_we_o) && $past(op_i, 2) == CPM_OP_INT
        |-> stack_we_o [*5] ##1 !stack_we_o)
        else $error("interrupt push count wrong");
    a_push_down: assert property (
        stack_we_o && $past(stack_we_o)
        |-> stack_addr_o[5:0] == $past(stack_addr_o[5:0]) - 6'h01)
        else $error("push did not step down");
    a_pull_up: assert property (
        stack_re_o && $past(stack_re_o)
        |-> stack_addr_o[5:0] == $past(stack_addr_o[5:0]) + 6'h01)
        else $error("pull did not step up");
    a_stack_home: assert property (
        op_i == CPM_OP_RSP && !stack_we_o && !stack_re_o
        |-> ##[1:2] stack_addr_o == SP_RESET)
        else $error("stack home not reached");
    a_ram_map: assert property (
        mem_addr_i inside {[RAM_LO:RAM_HI]} |=> region_o == CPM_REG_RAM)
        else $error("ram decode wrong");
    a_eprom_map: assert property (
        mem_addr_i inside {[EPROM_LO:EPROM_HI]}
        |=> region_o == CPM_REG_EPROM) else $error("eprom decode wrong");
    a_vec_map: assert property (
        mem_addr_i inside {[VEC_LO:VEC_HI]} |=> region_o == CPM_REG_VEC)
        else $error("vector decode wrong");
    a_option_map: assert property (
        mem_addr_i == OPTION_ADDR |=> region_o == CPM_REG_OPTION)
        else $error("option decode wrong");
    a_boot_map: assert property (
        mem_addr_i inside {[BOOT_LO:BOOT_HI]} |=> region_o == CPM_REG_BOOT)
        else $error("boot decode wrong");
endmodule // cpm_core_assertions

bind cpm_core cpm_core_assertions u_cpm_core_assertions (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .op_i(op_i),
    .mem_addr_i(mem_addr_i),
    .stack_addr_o(stack_addr_o),
    .stack_we_o(stack_we_o),
    .stack_re_o(stack_re_o),
    .region_o(region_o)
);

// File: tb/testbench.sv
// testbench: self-checking scenarios for the programmers model block
`timescale 1ns/100ps
module testbench;
    import cpm_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    cpm_op_t op_i = CPM_OP_NONE;
    logic [7:0] alu_result_i = 8'h00;
    logic alu_half_i = 1'b0;
    logic alu_carry_i = 1'b0;
    logic alu_is_add_i = 1'b0;
    logic alu_to_index_i = 1'b0;
    logic [12:0] jump_addr_i = 13'h0000;
    logic [12:0] mem_addr_i = 13'h0000;
    logic ext_irq_i = 1'b0;
    logic timer_irq_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [12:0] stack_addr_o;
    logic [7:0] stack_wdata_o;
    logic stack_we_o;
    logic stack_re_o;
    logic [2:0] region_o;
    logic int_pending_o;
    logic [7:0] v;
    int n_mismatch = 0;
    int checks_done = 0;

    // -------------------------------------------------------------------
    // clock and design
    // -------------------------------------------------------------------
    always #2 core_clk_i = ~core_clk_i;

    cpm_core u_cpm_core (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .op_i(op_i), .alu_result_i(alu_result_i), .alu_half_i(alu_half_i),
        .alu_carry_i(alu_carry_i), .alu_is_add_i(alu_is_add_i),
        .alu_to_index_i(alu_to_index_i), .jump_addr_i(jump_addr_i),
        .mem_addr_i(mem_addr_i), .ext_irq_i(ext_irq_i),
        .timer_irq_i(timer_irq_i),
        .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o),
        .stack_we_o(stack_we_o), .stack_re_o(stack_re_o),
        .region_o(region_o), .int_pending_o(int_pending_o));

    // -------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic run_op(input cpm_op_t o, input logic [12:0] tgt);
        @(posedge core_clk_i);
        op_i <= o;
        jump_addr_i <= tgt;
        @(posedge core_clk_i);
        op_i <= CPM_OP_NONE;
    endtask

    task automatic alu_op(input logic [7:0] r, input logic [2:0] hca,
                          input logic to_x);
        @(posedge core_clk_i);
        alu_result_i <= r;
        {alu_half_i, alu_carry_i, alu_is_add_i} <= hca;
        alu_to_index_i <= to_x;
        op_i <= CPM_OP_ALU;
        @(posedge core_clk_i);
        op_i <= CPM_OP_NONE;
    endtask

    // follows the byte strobes that start the cycle after the op is taken
    task automatic expect_stack(input logic push, input int n,
                                input logic [5:0] low0, input logic [39:0] b);
        logic [5:0] lo;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            #1;
            lo = push ? low0 - 6'(i) : low0 + 6'(i);
            check("stack strobe", push ? stack_we_o : stack_re_o, 1'b1);
            check("stack addr", stack_addr_o, {7'h03, lo});
            if (push) check("stack data", stack_wdata_o, b[8*i +: 8]);
        end
        @(posedge core_clk_i);
        #1;
        check("stack idle", stack_we_o | stack_re_o, 1'b0);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_regs();
        check("stack home", stack_addr_o, SP_RESET);
        rd(OFS_PC_HI, v);
        check("pc high", v, 8'h1f);
        rd(OFS_FLAGS, v);
        check("flags", v[4:0], 5'h08);
        wr(OFS_ACC, 8'h5a);
        rd(OFS_ACC, v);
        check("accumulator", v, 8'h5a);
        rd(4'h8, v);
        check("unmapped", v, 8'h00);
        wr(OFS_IDX, 8'h55);
        alu_op(8'h80, 3'b111, 1'b0);
        rd(OFS_FLAGS, v);
        check("flags add", v[4:0], 5'h1d);
        alu_op(8'h00, 3'b001, 1'b1);
        rd(OFS_IDX, v);
        check("index", v, 8'h00);
        rd(OFS_ACC, v);
        check("accumulator", v, 8'h80);
        rd(OFS_FLAGS, v);
        check("flags zero", v[4:0], 5'h0a);
    endtask

    task automatic t_stack();
        run_op(CPM_OP_JUMP, 13'h1234);
        run_op(CPM_OP_CALL, 13'h0000);
        expect_stack(1'b1, 2, 6'h3f, 40'h12_34);
        rd(OFS_SPADDR_LO, v);
        check("stack low", v, 8'hfd);
        rd(OFS_SP, v);
        check("push pointer", v, 8'h3d);
        run_op(CPM_OP_RTS, 13'h0000);
        expect_stack(1'b0, 2, 6'h3e, 40'h0);
        wr(OFS_ACC, 8'ha5);
        wr(OFS_IDX, 8'h3c);
        wr(OFS_FLAGS, 8'h08);
        run_op(CPM_OP_JUMP, 13'h0b00);
        @(posedge core_clk_i);
        ext_irq_i <= 1'b1;
        timer_irq_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1 check("pending masked", int_pending_o, 1'b0);
        run_op(CPM_OP_CLI, 13'h0000);
        repeat (4) @(posedge core_clk_i);
        #1 check("pending open", int_pending_o, 1'b1);
        ext_irq_i <= 1'b0;
        timer_irq_i <= 1'b0;
        run_op(CPM_OP_INT, 13'h0000);
        expect_stack(1'b1, 5, 6'h3f, 40'he0_a53c_0b00);
        rd(OFS_FLAGS, v);
        check("mask after entry", v[3], 1'b1);
        rd(OFS_STATUS, v);
        check("timer kept", v, 8'h01);
        run_op(CPM_OP_RTI, 13'h0000);
        expect_stack(1'b0, 5, 6'h3b, 40'h0);
        run_op(CPM_OP_CLI, 13'h0000);
        repeat (2) @(posedge core_clk_i);
        #1 check("timer pending", int_pending_o, 1'b1);
    endtask

    task automatic t_wrap();
        repeat (32) begin
            run_op(CPM_OP_CALL, 13'h0000);
            repeat (3) @(posedge core_clk_i);
        end
        #1 check("stack wrap", stack_addr_o, SP_RESET);
        run_op(CPM_OP_CALL, 13'h0000);
        repeat (3) @(posedge core_clk_i);
        run_op(CPM_OP_RSP, 13'h0000);
        repeat (2) @(posedge core_clk_i);
        #1 check("stack home op", stack_addr_o, SP_RESET);
        run_op(CPM_OP_JUMP, 13'h1fff);
        run_op(CPM_OP_INC_PC, 13'h0000);
        rd(OFS_PC_LO, v);
        check("pc low wrap", v, 8'h00);
        rd(OFS_PC_HI, v);
        check("pc high wrap", v, 8'h00);
        run_op(CPM_OP_SEI, 13'h0000);
        rd(OFS_FLAGS, v);
        check("mask set", v[3], 1'b1);
        check("pending blocked", int_pending_o, 1'b0);
    endtask

    task automatic t_decode();
        logic [15:0] tbl [12] = '{16'h007f, 16'h0080, 16'h01ff, 16'h0200,
            16'h0aff, 16'h0b00, 16'h1eff, 16'h1f00, 16'h1f01, 16'h1fef,
            16'h1ff0, 16'h1fff};
        logic [2:0] exp [12] = '{CPM_REG_NONE, CPM_REG_RAM, CPM_REG_RAM,
            CPM_REG_NONE, CPM_REG_NONE, CPM_REG_EPROM, CPM_REG_EPROM,
            CPM_REG_OPTION, CPM_REG_BOOT, CPM_REG_BOOT, CPM_REG_VEC,
            CPM_REG_VEC};
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk_i);
            mem_addr_i <= tbl[i][12:0];
            @(posedge core_clk_i);
            #1 check("region", region_o, exp[i]);
        end
    endtask

    // -------------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        t_regs();
        t_stack();
        t_wrap();
        t_decode();
        final_report();
    end

    initial begin
        #(20000 * 4);
        n_mismatch++;
        final_report();
    end
endmodule // testbench
